//--- aofrs_top.sv
// Output word formatter with reference select and post-reset data-ready behaviour.
`timescale 1ns/1ps
// How it works
// [R1] Every channel sample leaves as a left-justified 24-bit word, unused low bits zero.
// [R2] One oversampling setting sets the resolution of both channels together.
// [R3] Ratio 256 keeps all 24 bits, full two's complement range.
// [R4] Ratio 128 gives 23 bits, bit 0 forced to zero.
// [R5] Ratio 64 gives 20 bits, four lowest bits zero.
// [R6] Ratio 32 gives 17 bits, seven lowest bits zero.
// [R7] External reference select cleared by default means internal reference for both channels.
// [R8] External reference select set means the two reference pins form a differential input.
// [R9] Host ignores data-ready pulses in the first 50 us after reset.
// [R10] After reset all settings return to default and data-ready pulses start.
// [R11] Host holds hardware reset low if analog supply rises first.
module aofrs_top
  import aofrs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] osr_sel_i,
  input wire logic ext_reference_select_i,
  input wire logic cfg_load_i,
  input wire logic [AOFRS_WORD_W-1:0] ch0_raw_i,
  input wire logic [AOFRS_WORD_W-1:0] ch1_raw_i,
  input wire logic raw_valid_i,
  output logic raw_ready_o,
  input wire logic sample_take_i,
  output logic [AOFRS_WORD_W-1:0] ch0_data_o,
  output logic [AOFRS_WORD_W-1:0] ch1_data_o,
  output logic sample_ready_pulse_n_o,
  output logic settled_o,
  output logic ref_internal_en_o,
  output logic ref_diff_en_o,
  output logic [1:0] osr_o
);
  aofrs_stream_if #(.W(AOFRS_FIFO_W)) fin ();
  aofrs_stream_if #(.W(AOFRS_FIFO_W)) fout ();

  logic [1:0] osr_reg;
  logic ext_ref_reg;
  logic [AOFRS_WORD_W-1:0] ch0_reg;
  logic [AOFRS_WORD_W-1:0] ch1_reg;
  logic drdy_n_reg;
  logic settled_reg;
  logic raw_ready_reg;
  logic [15:0] settle_cnt_reg;
  aofrs_state_t state_reg;
  aofrs_state_t state_next;

  // Returns the mask that clears bits below the resolution of the chosen ratio.
  function automatic logic [AOFRS_WORD_W-1:0] res_mask(input logic [1:0] osr);
    logic [AOFRS_WORD_W-1:0] m;
    m = AOFRS_MASK_256;
    case (osr)
      AOFRS_OSR_32: m = AOFRS_MASK_32; // [R6]
      AOFRS_OSR_64: m = AOFRS_MASK_64; // [R5]
      AOFRS_OSR_128: m = AOFRS_MASK_128; // [R4]
      default: m = AOFRS_MASK_256; // [R3]
    endcase
    return m;
  endfunction

  // Left-justified input with low bits zeroed to the resolution.
  function automatic logic [AOFRS_WORD_W-1:0] fmt(input logic [AOFRS_WORD_W-1:0] raw,
                                                  input logic [1:0] osr);
    return raw & res_mask(osr); // [R1]
  endfunction

  // Configuration held in flip-flops; reset restores defaults.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      osr_reg <= AOFRS_OSR_RESET; // [R10]
      ext_ref_reg <= AOFRS_EXT_REF_RESET; // [R7]
    end else if (cfg_load_i) begin
      osr_reg <= osr_sel_i;
      ext_ref_reg <= ext_reference_select_i;
    end
  end

  // Reference routing for both channels.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ref_internal_en_o <= 1'b1;
      ref_diff_en_o <= 1'b0;
    end else begin
      ref_internal_en_o <= !ext_ref_reg; // [R7]
      ref_diff_en_o <= ext_ref_reg; // [R8]
    end
  end

  // Both channels are formatted with the same setting into one FIFO word.
  assign fin.data = {fmt(ch1_raw_i, osr_reg), fmt(ch0_raw_i, osr_reg)}; // [R2]
  assign fin.valid = raw_valid_i;

  aofrs_fifo #(.WIDTH(AOFRS_FIFO_W), .DEPTH(AOFRS_FIFO_DEPTH)) u_fifo (
    .clk_i(clk_i),
    .rstn_i(rstn_i),
    .in_s(fin),
    .out_s(fout)
  );

  // Ready to the source follows FIFO space, registered.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      raw_ready_reg <= 1'b0;
    end else begin
      raw_ready_reg <= fin.ready;
    end
  end
  assign raw_ready_o = raw_ready_reg;

  // Counts the settling window after reset.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      settle_cnt_reg <= '0;
      settled_reg <= 1'b0;
    end else if (settle_cnt_reg != 16'(AOFRS_SETTLE_CYC)) begin
      settle_cnt_reg <= settle_cnt_reg + 1'b1;
    end else begin
      settled_reg <= 1'b1; // [R9]
    end
  end
  assign settled_o = settled_reg;

  // Presentation sequencer: pulses stay on, even before settling.
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      AOFRS_ST_SETTLE: begin
        state_next = AOFRS_ST_IDLE; // [R10]
      end
      AOFRS_ST_IDLE: begin
        if (fout.valid && !sample_take_i) begin
          state_next = AOFRS_ST_PULSE;
        end
      end
      default: begin
        state_next = AOFRS_ST_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= AOFRS_ST_SETTLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Pop the FIFO when a new word is presented.
  assign fout.ready = (state_reg == AOFRS_ST_IDLE) && fout.valid && !sample_take_i;

  // Output words and active-low one-cycle data-ready pulse.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      ch0_reg <= '0;
      ch1_reg <= '0;
      drdy_n_reg <= 1'b1;
    end else begin
      drdy_n_reg <= 1'b1;
      if (fout.ready) begin
        ch0_reg <= fout.data[AOFRS_WORD_W-1:0]; // [R1]
        ch1_reg <= fout.data[AOFRS_FIFO_W-1:AOFRS_WORD_W];
        drdy_n_reg <= 1'b0; // [R10]
      end
    end
  end
  assign ch0_data_o = ch0_reg;
  assign ch1_data_o = ch1_reg;
  assign sample_ready_pulse_n_o = drdy_n_reg;
  assign osr_o = osr_reg;
endmodule

//--- aofrs_pkg.sv
// Package with constants and types for the output format and reference select block.
package aofrs_pkg;
  localparam int AOFRS_WORD_W = 24;
  localparam int AOFRS_FIFO_DEPTH = 4;
  localparam int AOFRS_FIFO_W = 2 * AOFRS_WORD_W;
  // Oversampling ratio codes.
  localparam logic [1:0] AOFRS_OSR_32 = 2'h0;
  localparam logic [1:0] AOFRS_OSR_64 = 2'h1;
  localparam logic [1:0] AOFRS_OSR_128 = 2'h2;
  localparam logic [1:0] AOFRS_OSR_256 = 2'h3;
  localparam logic [1:0] AOFRS_OSR_RESET = AOFRS_OSR_256;
  // Low-order masks that keep only the resolved bits.
  localparam logic [23:0] AOFRS_MASK_256 = 24'hFFFFFF;
  localparam logic [23:0] AOFRS_MASK_128 = 24'hFFFFFE;
  localparam logic [23:0] AOFRS_MASK_64 = 24'hFFFFF0;
  localparam logic [23:0] AOFRS_MASK_32 = 24'hFFFF80;
  localparam logic AOFRS_EXT_REF_RESET = 1'b0;
  // Settling time after reset in ns and derived cycles at 100 MHz.
  localparam int AOFRS_SETTLE_NS = 50000;
  localparam int AOFRS_CLK_NS = 10;
  localparam int AOFRS_SETTLE_CYC = (AOFRS_SETTLE_NS + AOFRS_CLK_NS - 1) / AOFRS_CLK_NS;
  localparam int AOFRS_PULSE_CYC = 1;
  typedef enum logic [1:0] {AOFRS_ST_SETTLE, AOFRS_ST_IDLE, AOFRS_ST_PULSE} aofrs_state_t;
endpackage

//--- aofrs_stream_if.sv
// Interface carrying a valid and ready word stream between the block's modules.
`timescale 1ns/1ps
interface aofrs_stream_if #(parameter int W = 48) ();
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface

//--- aofrs_fifo.sv
// Small flip-flop FIFO with valid and ready on both sides.
`timescale 1ns/1ps
module aofrs_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  aofrs_stream_if.snk in_s,
  aofrs_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic push;
  logic pop;

  // Handshakes on both sides; full and empty come from the count.
  assign in_s.ready = (cnt_reg < (AW+1)'(DEPTH)); // Room while fewer than DEPTH words are held.
  assign out_s.valid = (cnt_reg != '0);
  assign out_s.data = mem_reg[rd_reg];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;

  // Storage write.
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_reg[wr_reg] <= in_s.data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (push) begin
        wr_reg <= (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
      end
      if (pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
      end
      if (push && !pop) begin
        cnt_reg <= cnt_reg + 1'b1;
      end else if (pop && !push) begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end
endmodule

//--- aofrs_monitor.sv
// Checker that watches the formatter's top-level ports.
`timescale 1ns/1ps
module aofrs_monitor
  import aofrs_pkg::*;
(
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [1:0] osr_sel_i,
  input wire logic ext_reference_select_i,
  input wire logic cfg_load_i,
  input wire logic [23:0] ch0_data_o,
  input wire logic [23:0] ch1_data_o,
  input wire logic sample_ready_pulse_n_o,
  input wire logic settled_o,
  input wire logic ref_internal_en_o,
  input wire logic ref_diff_en_o,
  input wire logic [1:0] osr_o
);
  logic [15:0] cnt_reg;
  logic [23:0] both;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // Either channel's stray low bit shows up in the merged word.
  assign both = ch0_data_o | ch1_data_o;
  // Counts cycles since reset release, saturating.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) cnt_reg <= 16'h0;
    else if (cnt_reg < 16'h2000) cnt_reg <= cnt_reg + 16'h1;
  end
  sequence s_int; cfg_load_i && !ext_reference_select_i; endsequence
  sequence s_ext; cfg_load_i && ext_reference_select_i; endsequence
  sequence s_word; !sample_ready_pulse_n_o ##1 sample_ready_pulse_n_o; endsequence
  a_osr128_low: assert property (!sample_ready_pulse_n_o && osr_o == AOFRS_OSR_128 |-> both[0] == 1'b0)
    else $error("low bit set at ratio 128");
  a_osr64_low: assert property (!sample_ready_pulse_n_o && osr_o == AOFRS_OSR_64 |-> both[3:0] == 4'h0)
    else $error("low bits set at ratio 64");
  a_osr32_low: assert property (!sample_ready_pulse_n_o && osr_o == AOFRS_OSR_32 |-> both[6:0] == 7'h0)
    else $error("low bits set at ratio 32");
  a_ref_internal: assert property (s_int |-> ##2 ref_internal_en_o && !ref_diff_en_o)
    else $error("internal reference not chosen");
  a_ref_diff: assert property (s_ext |-> ##2 ref_diff_en_o && !ref_internal_en_o)
    else $error("differential reference not chosen");
  a_osr_load: assert property (cfg_load_i |=> osr_o == $past(osr_sel_i))
    else $error("ratio not loaded");
  a_pulse_single: assert property (!sample_ready_pulse_n_o |-> s_word)
    else $error("ready pulse longer than one cycle");
  a_reset_default: assert property ($rose(rstn_i) |-> osr_o == AOFRS_OSR_256 && ref_internal_en_o)
    else $error("settings not default after reset");
  a_settle_early: assert property (cnt_reg < 16'h1386 |-> !settled_o)
    else $error("settled too early");
  a_settle_late: assert property (cnt_reg > 16'h138A |-> settled_o)
    else $error("settled too late");
endmodule
bind aofrs_top aofrs_monitor u_mon (.*);

//--- aofrs_host_model.sv
// Host model that stalls the block and flags words that are worth reading.
`timescale 1ns/1ps
module aofrs_host_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic hold_i,
  input wire logic rnd_i,
  input wire logic pulse_n_i,
  input wire logic settled_i,
  output logic take_o,
  output logic got_o
);
  // Stall level follows hold or a coin toss; words before settling are skipped.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      take_o <= 1'b0;
      got_o <= 1'b0;
    end else begin
      take_o <= hold_i || (rnd_i && $urandom_range(1) == 1);
      got_o <= !pulse_n_i && settled_i;
    end
  end
endmodule

//--- tb_aofrs_top.sv
// Self-checking testbench for the output formatter.
`timescale 1ns/1ps
module tb_aofrs_top;
  import aofrs_pkg::*;
  logic clk_i = 1'b0, rstn_i = 1'b0, cfg_load_i = 1'b0, ext_reference_select_i = 1'b0, raw_valid_i = 1'b0;
  logic hold = 1'b0, rnd = 1'b0, got, raw_ready_o, sample_take_i, sample_ready_pulse_n_o, settled_o;
  logic ref_internal_en_o, ref_diff_en_o;
  logic [1:0] osr_sel_i = 2'h3, cur = 2'h3, osr_o;
  logic [23:0] ch0_raw_i = 24'h0, ch1_raw_i = 24'h0, ch0_data_o, ch1_data_o;
  logic [47:0] q[$];
  int miscompares = 0, n_tests = 0, n;
  aofrs_top DUT (.*);
  aofrs_host_model host (.clk_i(clk_i), .rstn_i(rstn_i), .hold_i(hold), .rnd_i(rnd),
    .pulse_n_i(sample_ready_pulse_n_o), .settled_i(settled_o), .take_o(sample_take_i), .got_o(got));
  // Free-running clock.
  always #5 clk_i = ~clk_i;
  function automatic logic [23:0] msk(input logic [1:0] o);
    return o == 2'h0 ? 24'hFFFF80 : o == 2'h1 ? 24'hFFFFF0 : o == 2'h2 ? 24'hFFFFFE : 24'hFFFFFF;
  endfunction
  task chk(input string nm, input logic [47:0] s, input logic [47:0] e);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h seen %h", nm, e, s);
    end
  endtask
  task test_done();
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task drain();
    n = 0;
    while (q.size() != 0 && n++ < 500) @(posedge clk_i);
  endtask
  task rst_chk();
    q.delete();
    rstn_i <= 1'b0;
    repeat (12) @(posedge clk_i);
    rstn_i <= 1'b1;
    cur = 2'h3;
    @(posedge clk_i);
    #1 chk("dflt", 48'({settled_o, osr_o, ref_internal_en_o, ref_diff_en_o}), 48'h0E);
  endtask
  task cfg(input logic [1:0] o, input logic x);
    drain();
    @(posedge clk_i);
    osr_sel_i <= o;
    ext_reference_select_i <= x;
    cfg_load_i <= 1'b1;
    cur = o;
    @(posedge clk_i);
    cfg_load_i <= 1'b0;
    #1 chk("osr", 48'(osr_o), 48'(o));
    @(posedge clk_i);
    #1 chk("ref", 48'({ref_internal_en_o, ref_diff_en_o}), 48'({!x, x}));
  endtask
  // Offers one pair once the FIFO shows room, then idles a cycle.
  task send(input logic [23:0] a, input logic [23:0] b);
    n = 0;
    do @(posedge clk_i); while (raw_ready_o !== 1'b1 && n++ < 300);
    q.push_back({b & msk(cur), a & msk(cur)});
    ch0_raw_i <= a;
    ch1_raw_i <= b;
    raw_valid_i <= 1'b1;
    @(posedge clk_i);
    raw_valid_i <= 1'b0;
  endtask
  // Compares each word the host reads with the oldest note.
  always @(posedge clk_i) begin
    if (got === 1'b1) chk("words", {ch1_data_o, ch0_data_o}, q.size() ? q.pop_front() : 48'hX);
  end
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    test_done();
  end
  initial begin
    void'($urandom(32'hE98BCD06));
    rst_chk();
    n = 0;
    while (settled_o !== 1'b1 && n++ < 6000) @(posedge clk_i);
    $display("test reset done");
    rnd <= 1'b1;
    for (int o = 0; o < 4; o++) begin
      cfg(2'(o), o[0]);
      send(24'h7FFFFF, 24'h800000);
      send(24'hFFFFFF, 24'h000001);
      send(24'($urandom), 24'($urandom));
    end
    $display("test ratios done");
    drain();
    rnd <= 1'b0;
    hold <= 1'b1;
    repeat (3) @(posedge clk_i);
    repeat (4) send(24'($urandom), 24'($urandom));
    repeat (3) @(posedge clk_i);
    #1 chk("full", 48'(raw_ready_o), 48'h0);
    @(posedge clk_i);
    hold <= 1'b0;
    drain();
    $display("test fill done");
    cfg(2'h0, 1'b1);
    rst_chk();
    $display("test rereset done");
    test_done();
  end
endmodule
